// file: hw/adc_mode_config_port.sv
// Top of the configuration port: strap choice, parallel decode, serial registers, power state
`timescale 1ns/1ns
`default_nettype none
module adc_mode_config_port (
    // System clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Strap
    input  wire logic       interface_select_strap,
    // Configuration pins; sclk is also the link clock
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdi,
    input  wire logic       sdo_in,
    output logic            sdo_out,
    output logic            sdo_oe_n,
    // Converter controls
    output logic            parallel_mode,
    output logic [1:0]      lane_mode,
    output logic            lvds_current_low,
    output logic            duty_stabilizer_disable,
    output logic            output_scramble_enable,
    output logic            signed_format_select,
    output logic            nap_ch1,
    output logic            nap_ch2,
    output logic            sleep,
    // Status
    output logic [7:0]      format_power_control,
    output logic            partial_word_dropped
);

    // Synchronised pins, order {strap, ~cs_n, sclk, sdi, sdo_in}
    logic [4:0]  pins_level;
    logic        strap_level;
    logic        cs_n_level;
    logic        sclk_level;
    logic        sdi_level;
    logic        sdo_level;

    // Serial link results
    logic [15:0] link_word;
    logic        link_frame_done;
    logic        link_sdo_pull;
    logic        frame_done_level;
    logic        frame_done_prev;
    logic        cs_n_prev;
    logic        frame_seen;
    logic        frame_open;

    // Command decode
    logic        take_word;
    logic        write_cmd;
    logic [6:0]  write_index;
    logic [7:0]  write_data;
    logic        soft_reset_hit;

    // Power control
    logic [7:0]  soft_sleep_count;
    adc_cfg_pkg::power_state_t power_state;
    adc_cfg_pkg::power_state_t next_power_state;

    // Write strobe for one register index
    function automatic logic index_write(input logic strobe, input logic [6:0] idx, input logic [6:0] target);
        return strobe && idx == target;
    endfunction

    // Unused pin code falls back to the reset default instead of an undefined lane count
    function automatic logic [1:0] lane_decode(input logic [1:0] pins);
        return (pins == adc_cfg_pkg::LANES_UNUSED) ? adc_cfg_pkg::LANES_TWO : pins;
    endfunction

    level_sync #(
        .WIDTH (5)
    ) pin_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in ({interface_select_strap, ~cs_n, sclk, sdi, sdo_in}),
        .level    (pins_level)
    );

    assign strap_level = pins_level[4];
    // Chip-select filtered inverted, so the cleared filter reads as idle and no false edge follows reset
    assign cs_n_level  = ~pins_level[3];
    assign sclk_level  = pins_level[2];
    assign sdi_level   = pins_level[1];
    assign sdo_level   = pins_level[0];

    serial_word_shifter link_side (
        .sclk            (sclk),
        .cs_n            (cs_n),
        .sdi             (sdi),
        .format_readback (format_power_control),
        .word            (link_word),
        .frame_done      (link_frame_done),
        .sdo_pull        (link_sdo_pull)
    );

    level_sync #(
        .WIDTH (1)
    ) frame_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (link_frame_done),
        .level    (frame_done_level)
    );

    // Pin never driven high; released entirely in parallel mode, where it is an input
    assign sdo_out  = 1'b0;
    assign sdo_oe_n = ~(link_sdo_pull & ~strap_level);

    // Registered copy of the strap, one cycle behind strap_level
    always_ff @(posedge clk)
    begin
        if (reset)
            parallel_mode <= 1'b0;
        else
            parallel_mode <= strap_level;
    end

    // Word is stable once the frame level is seen; it only changes at the next full frame
    always_ff @(posedge clk)
    begin
        if (reset)
            frame_done_prev <= 1'b0;
        else
            frame_done_prev <= frame_done_level;
    end

    // Acts on the rising level only, so a word held high is never applied twice
    assign take_word      = frame_done_level & ~frame_done_prev & ~strap_level;
    assign write_cmd      = take_word & ~link_word[adc_cfg_pkg::DIR_POS];
    assign write_index    = link_word[adc_cfg_pkg::INDEX_MSB:adc_cfg_pkg::INDEX_LSB];
    assign write_data     = link_word[adc_cfg_pkg::DATA_MSB:0];
    assign soft_reset_hit = index_write(write_cmd, write_index, adc_cfg_pkg::IDX_SOFT_RESET)
                            && write_data[adc_cfg_pkg::SOFT_RESET_POS];

    // Frame tracking to flag words cut short by chip-select
    always_ff @(posedge clk)
    begin
        if (reset)
            cs_n_prev <= 1'b1;
        else
            cs_n_prev <= cs_n_level;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            frame_seen <= 1'b0;
        else if (cs_n_level && !cs_n_prev)
            frame_seen <= 1'b0;
        else if (frame_done_level)
            frame_seen <= 1'b1;
    end

    // A frame opens only in serial mode, so leaving parallel mode never reports a cut word
    always_ff @(posedge clk)
    begin
        if (reset)
            frame_open <= 1'b0;
        else if (cs_n_level && !cs_n_prev)
            frame_open <= 1'b0;
        else if (!cs_n_level && cs_n_prev && !strap_level)
            frame_open <= 1'b1;
    end

    // Partial word: nothing is written, only reported
    always_ff @(posedge clk)
    begin
        if (reset)
            partial_word_dropped <= 1'b0;
        else
            partial_word_dropped <= cs_n_level && !cs_n_prev
                                    && frame_open && !frame_seen
                                    && !frame_done_level && !strap_level;
    end

    // Format/power register; software reset wins over any other update
    always_ff @(posedge clk)
    begin
        if (reset)
            format_power_control <= adc_cfg_pkg::FORMAT_POWER_RESET;
        else if (soft_reset_hit)
            format_power_control <= adc_cfg_pkg::FORMAT_POWER_RESET;
        else if (index_write(write_cmd, write_index, adc_cfg_pkg::IDX_FORMAT_POWER))
            format_power_control <= write_data;
    end

    // Reset bit is never stored, so it reads back as zero once the write is done
    always_ff @(posedge clk)
    begin
        if (reset)
            soft_sleep_count <= 8'h00;
        else if (soft_reset_hit)
            soft_sleep_count <= adc_cfg_pkg::SOFT_SLEEP_CYCLES;
        else if (power_state == adc_cfg_pkg::PWR_RESET_SLEEP
                 && soft_sleep_count != 8'h00)
            soft_sleep_count <= soft_sleep_count - 8'h01;
    end

    // Power state: momentary reset sleep overrides strap and register
    always_comb
    begin
        next_power_state = adc_cfg_pkg::PWR_RUN;
        if (soft_reset_hit || soft_sleep_count != 8'h00)
            next_power_state = adc_cfg_pkg::PWR_RESET_SLEEP;
        else if (strap_level)
        begin
            if (sdi_level)
                next_power_state = adc_cfg_pkg::PWR_SLEEP;
        end
        else if (format_power_control[adc_cfg_pkg::FMT_SLEEP_POS])
            next_power_state = adc_cfg_pkg::PWR_SLEEP;
        else if (format_power_control[adc_cfg_pkg::FMT_NAP2_POS]
                 || format_power_control[adc_cfg_pkg::FMT_NAP1_POS])
            next_power_state = adc_cfg_pkg::PWR_NAP;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            power_state <= adc_cfg_pkg::PWR_RUN;
        else
            power_state <= next_power_state;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sleep   <= 1'b0;
            nap_ch1 <= 1'b0;
            nap_ch2 <= 1'b0;
        end
        else
        begin
            unique case (next_power_state)
                adc_cfg_pkg::PWR_RUN:
                begin
                    sleep   <= 1'b0;
                    nap_ch1 <= 1'b0;
                    nap_ch2 <= 1'b0;
                end
                adc_cfg_pkg::PWR_NAP:
                begin
                    // Either channel, or both, may nap together
                    sleep   <= 1'b0;
                    nap_ch1 <= format_power_control[adc_cfg_pkg::FMT_NAP1_POS];
                    nap_ch2 <= format_power_control[adc_cfg_pkg::FMT_NAP2_POS];
                end
                adc_cfg_pkg::PWR_SLEEP,
                adc_cfg_pkg::PWR_RESET_SLEEP:
                begin
                    sleep   <= 1'b1;
                    nap_ch1 <= 1'b0;
                    nap_ch2 <= 1'b0;
                end
            endcase
        end
    end

    // Lane mode: pins in parallel mode; serial mode holds the two-lane default
    always_ff @(posedge clk)
    begin
        if (reset)
            lane_mode <= adc_cfg_pkg::LANES_TWO;
        else if (strap_level)
            lane_mode <= lane_decode({cs_n_level, sclk_level});
        else
            lane_mode <= adc_cfg_pkg::LANES_TWO;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            lvds_current_low <= 1'b0;
        else
            lvds_current_low <= strap_level & sdo_level;
    end

    // Formatting bits only exist in serial mode; no pin can turn the stabilizer off
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            duty_stabilizer_disable <= 1'b0;
            output_scramble_enable  <= 1'b0;
            signed_format_select    <= 1'b0;
        end
        else if (strap_level)
        begin
            duty_stabilizer_disable <= 1'b0;
            output_scramble_enable  <= 1'b0;
            signed_format_select    <= 1'b0;
        end
        else
        begin
            duty_stabilizer_disable <= format_power_control[adc_cfg_pkg::FMT_DCS_OFF_POS];
            output_scramble_enable  <= format_power_control[adc_cfg_pkg::FMT_SCRAMBLE_POS];
            signed_format_select    <= format_power_control[adc_cfg_pkg::FMT_TWOS_POS];
        end
    end

endmodule
`default_nettype wire

// file: hw/adc_cfg_pkg.sv
// Constants, field layouts and types shared by the configuration port files
// What this block does
// - Strap high turns the four configuration pins into static mode inputs.
// - Parallel mode: chip-select and clock pins pick lanes 00=two 01=four 10=one.
// - Parallel mode: serial-in low runs normally, high puts the converter asleep.
// - Parallel mode: serial-out pin low gives 3.5mA drive, high gives 1.75mA.
// - Strap low turns the four pins into a serial register port.
// - Frame runs while chip-select low; only first 16 rising clock edges sample.
// - Word is direction bit, seven-bit index, eight data bits, MSB first.
// - Direction low writes the data byte into the indexed register.
// - Direction high shifts the register out, leaves it intact, ignores data.
// - Serial-out only pulls low; the host supplies the pull-up for readback.
// - Reset bit clears all mode registers, sleeps briefly, and self-clears.
// - Reset register is write-only; readback value carries no meaning.
// - Format bit 7 low keeps duty stabilizer on, high turns it off.
// - Format bit 6 enables output scrambling.
// - Format bit 5 selects two's complement, clear selects offset binary.
// - Format bits 4,3,0: sleep both, nap channel 2, nap channel 1.
// - Parallel mode keeps the duty stabilizer always enabled.
package adc_cfg_pkg;

    // Serial word layout
    localparam int WORD_BITS      = 16;
    localparam int DATA_BITS      = 8;
    localparam int INDEX_BITS     = 7;
    localparam int DIR_POS        = 15;
    localparam int INDEX_MSB      = 14;
    localparam int INDEX_LSB      = 8;
    localparam int DATA_MSB       = 7;
    localparam logic [4:0] FRAME_EDGES    = 5'h10;
    localparam logic [4:0] DATA_FIRST_EDGE = 5'h08;

    // Register indices
    localparam logic [6:0] IDX_SOFT_RESET   = 7'h00;
    localparam logic [6:0] IDX_FORMAT_POWER = 7'h01;

    // Reset register fields
    localparam int SOFT_RESET_POS = 7;
    localparam logic [7:0] SOFT_RESET_READBACK = 8'h00;

    // Format/power register fields
    localparam int FMT_DCS_OFF_POS  = 7;
    localparam int FMT_SCRAMBLE_POS = 6;
    localparam int FMT_TWOS_POS     = 5;
    localparam int FMT_SLEEP_POS    = 4;
    localparam int FMT_NAP2_POS     = 3;
    localparam int FMT_NAP1_POS     = 0;
    localparam logic [7:0] FORMAT_POWER_RESET = 8'h00;

    // Lane mode codes
    localparam logic [1:0] LANES_TWO    = 2'h0;
    localparam logic [1:0] LANES_FOUR   = 2'h1;
    localparam logic [1:0] LANES_ONE    = 2'h2;
    localparam logic [1:0] LANES_UNUSED = 2'h3;

    // Timing
    localparam int CLK_PERIOD_NS      = 10;
    localparam int SOFT_SLEEP_NS      = 1000;
    localparam int SOFT_SLEEP_CYCLES_INT = (SOFT_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SOFT_SLEEP_CYCLES = 8'(SOFT_SLEEP_CYCLES_INT);

    typedef enum logic [3:0] {
        PWR_RUN         = 4'h1,
        PWR_NAP         = 4'h2,
        PWR_SLEEP       = 4'h4,
        PWR_RESET_SLEEP = 4'h8
    } power_state_t;

endpackage

// file: hw/level_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Asynchronous levels in, filtered levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Only bits whose last two stages agree move
    always_ff @(posedge clk)
    begin
        if (reset)
            level <= '0;
        else
            level <= (level & ~(stage2 ^~ stage3)) | (stage3 & (stage2 ^~ stage3));
    end

endmodule
`default_nettype wire

// file: hw/serial_word_shifter.sv
// Link-clock side of the serial port: shift-in, frame complete level, readback drive
`timescale 1ns/1ns
`default_nettype none
module serial_word_shifter (
    // Link pins
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    // Readback source, steady during a frame
    input  wire logic [7:0]  format_readback,
    // Captured word and its frame-complete level
    output logic      [15:0] word,
    output logic             frame_done,
    // Open-drain pull request
    output logic             sdo_pull
);

    logic [4:0]  edge_count;
    logic [14:0] shift;
    logic        read_cmd;
    logic [6:0]  read_index;
    logic [7:0]  read_byte;

    // Chip-select high ends the frame and clears all frame state
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            edge_count <= 5'h00;
        else if (edge_count != adc_cfg_pkg::FRAME_EDGES)
            edge_count <= edge_count + 5'h01;
    end

    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            shift <= 15'h0000;
        else if (edge_count != adc_cfg_pkg::FRAME_EDGES)
            shift <= {shift[13:0], sdi};
    end

    // Word held past the frame so the system side can copy it at leisure
    always_ff @(posedge sclk)
    begin
        if (!cs_n && edge_count == adc_cfg_pkg::FRAME_EDGES - 5'h01)
            word <= {shift, sdi};
    end

    // Level only for full frames; a flop, so no decode glitch reaches the synchroniser
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            frame_done <= 1'b0;
        else if (edge_count == adc_cfg_pkg::FRAME_EDGES - 5'h01)
            frame_done <= 1'b1;
    end

    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
        begin
            read_cmd   <= 1'b0;
            read_index <= 7'h00;
        end
        else if (edge_count == adc_cfg_pkg::DATA_FIRST_EDGE - 5'h01)
        begin
            read_cmd   <= shift[6];
            read_index <= {shift[5:0], sdi};
        end
    end

    // Reset register reads as a fixed value the host must not trust
    assign read_byte = (read_index == adc_cfg_pkg::IDX_FORMAT_POWER) ? format_readback
                                                                    : adc_cfg_pkg::SOFT_RESET_READBACK;

    // Bits change on falling edges so the host samples on rising ones
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
            sdo_pull <= 1'b0;
        else if (read_cmd && edge_count[4:3] == 2'h1)
            sdo_pull <= ~read_byte[3'h7 - edge_count[2:0]];
        else
            sdo_pull <= 1'b0;
    end

endmodule
`default_nettype wire

// file: sim/cfg_port_props.sv
// Concurrent checks on the configuration port pins
`timescale 1ns/1ns
`default_nettype none
module cfg_port_props (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // Pins
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       sdi,
    input wire logic       sdo_in,
    input wire logic       sdo_out,
    input wire logic       sdo_oe_n,
    // Controls and status
    input wire logic       parallel_mode,
    input wire logic [1:0] lane_mode,
    input wire logic       lvds_current_low,
    input wire logic       duty_stabilizer_disable,
    input wire logic       output_scramble_enable,
    input wire logic       signed_format_select,
    input wire logic       nap_ch1,
    input wire logic       nap_ch2,
    input wire logic       sleep,
    input wire logic [7:0] format_power_control,
    input wire logic       partial_word_dropped
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic ser;
    assign ser = ~parallel_mode;

    // Pins must settle through the synchroniser before outputs follow
    par_lane_a: assert property ((parallel_mode && $stable({cs_n, sclk}))[*8] |->
        lane_mode == {cs_n, sclk} || {cs_n, sclk} == 2'h3) else $error("lane mode differs from pins");
    par_sleep_a: assert property ((parallel_mode && $stable(sdi))[*8] |-> sleep == sdi)
        else $error("sleep differs from pin");
    par_drive_a: assert property ((parallel_mode && $stable(sdo_in))[*8] |-> lvds_current_low == sdo_in)
        else $error("drive select differs from pin");
    par_dcs_a: assert property (parallel_mode |-> !duty_stabilizer_disable)
        else $error("stabilizer off in parallel mode");
    par_hold_a: assert property (parallel_mode && $past(parallel_mode) |-> $stable(format_power_control))
        else $error("register changed in parallel mode");
    fmt_bits_a: assert property (ser && $past(ser) |-> {duty_stabilizer_disable, output_scramble_enable,
        signed_format_select} == $past(format_power_control[7:5])) else $error("format outputs differ");
    pwr_sleep_a: assert property (ser && $past(ser) && $past(format_power_control[4]) |->
        sleep && !nap_ch1 && !nap_ch2) else $error("sleep code not obeyed");
    pwr_nap_a: assert property (ser && $past(ser) && !sleep |-> nap_ch1 == $past(format_power_control[0])
        && nap_ch2 == $past(format_power_control[3])) else $error("nap outputs differ");
    pull_idle_a: assert property (parallel_mode || cs_n && $past(cs_n) |-> sdo_oe_n && !sdo_out)
        else $error("readback line pulled while idle");
    drop_pulse_a: assert property ($rose(partial_word_dropped) |-> cs_n ##1 !partial_word_dropped)
        else $error("drop pulse malformed");

    cover property (ser && sleep);
    cover property (partial_word_dropped);
    cover property (parallel_mode && lane_mode == 2'h2);
endmodule
bind adc_mode_config_port cfg_port_props chk (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo_in(sdo_in), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .parallel_mode(parallel_mode),
    .lane_mode(lane_mode), .lvds_current_low(lvds_current_low), .duty_stabilizer_disable(duty_stabilizer_disable),
    .output_scramble_enable(output_scramble_enable), .signed_format_select(signed_format_select),
    .nap_ch1(nap_ch1), .nap_ch2(nap_ch2), .sleep(sleep), .format_power_control(format_power_control),
    .partial_word_dropped(partial_word_dropped));
`default_nettype wire

// file: sim/spi_host_model.sv
// Host side of the serial configuration link
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    // Readback wire level
    input  wire logic  sdo_wire,
    // Link pins
    output logic       sclk,
    output logic       cs_n,
    output logic       sdi,
    // Byte captured by the last frame
    output logic [7:0] read_byte
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        read_byte = 8'h00;
    end

    // Clock runs only inside a frame; extra edges carry junk
    task automatic frame(input logic [15:0] word, input int edges, input int half);
        cs_n = 1'b0;
        for (int i = 0; i < edges; i++)
        begin
            sdi = (i < 16) ? word[15 - i] : ~sdi;
            #(half);
            sclk = 1'b1;
            if (i >= 8 && i < 16)
                read_byte[15 - i] = sdo_wire;
            #(half);
            sclk = 1'b0;
        end
        #(half);
        cs_n = 1'b1;
        sdi = ~sdi;
        #(3 * half);
    endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the configuration port in both pin modes
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [55:0] PATS = 56'h00_01_08_09_10_19_e0;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        strap = 1'b0;
    logic [3:0]  par = 4'h0;
    logic        h_sclk, h_cs_n, h_sdi, sdo_wire, sdo_out, sdo_oe_n, pmode, lvds, dsd, scr, sfs, nap1, nap2, slp;
    logic        drop;
    logic [1:0]  lane;
    logic [7:0]  rb, fpc, last_fpc, mf, d;
    logic [7:0]  exp_q[$];
    logic [31:0] rnd = 32'h000073b2;
    int          fails = 0, check_count = 0, cycles = 0, drops = 0, d0;

    always #5 clk = ~clk;
    assign sdo_wire = sdo_oe_n ? 1'b1 : sdo_out;

    spi_host_model host (.sdo_wire(sdo_wire), .sclk(h_sclk), .cs_n(h_cs_n), .sdi(h_sdi), .read_byte(rb));
    adc_mode_config_port dut (.clk(clk), .reset(reset), .interface_select_strap(strap),
        .sclk(strap ? par[2] : h_sclk), .cs_n(strap ? par[3] : h_cs_n), .sdi(strap ? par[1] : h_sdi),
        .sdo_in(strap ? par[0] : sdo_wire), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .parallel_mode(pmode),
        .lane_mode(lane), .lvds_current_low(lvds), .duty_stabilizer_disable(dsd), .output_scramble_enable(scr),
        .signed_format_select(sfs), .nap_ch1(nap1), .nap_ch2(nap2), .sleep(slp),
        .format_power_control(fpc), .partial_word_dropped(drop));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic end_of_test();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register changes are matched against the oldest expected value; an unplanned change fails
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (reset)
            last_fpc <= 8'h00;
        else if (fpc !== last_fpc)
        begin
            last_fpc <= fpc;
            cmp(fpc, exp_q.size() > 0 ? exp_q.pop_front() : last_fpc);
        end
        if (!reset && drop === 1'b1)
            drops <= drops + 1;
        if (cycles == 20000)
        begin
            fails++;
            end_of_test();
        end
    end

    task automatic wr(input logic [6:0] idx, input logic [7:0] v, input int edges, input int half);
        logic [7:0] nf;
        nf = (edges < 16) ? mf : (idx == 7'h01) ? v : (idx == 7'h00 && v[7]) ? 8'h00 : mf;
        if (nf !== mf)
            exp_q.push_back(nf);
        mf = nf;
        host.frame({1'b0, idx, v}, edges, half);
        repeat (12) @(negedge clk);
    endtask

    task automatic chk_out();
        cmp({dsd, scr, sfs}, mf[7:5]);
        cmp({slp, nap2, nap1}, mf[4] ? 8'h4 : {mf[3], mf[0]});
    endtask

    initial
    begin
        mf = 8'h00;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        wr(7'h00, 8'h80, 16, 32);
        cmp(slp, 1'b1);
        repeat (110) @(negedge clk);
        cmp(slp, 1'b0);
        for (int i = 0; i < 12; i++)
        begin
            rnd = xs(rnd);
            d = (i < 7) ? PATS[55 - 8 * i -: 8] : rnd[7:0];
            wr(7'h01, d, 16, 32);
            chk_out();
            host.frame({1'b1, 7'h01, ~mf}, 16, 32);
            cmp(rb, mf);
        end
        host.frame({1'b1, 7'h00, 8'hff}, 16, 32);
        wr(7'h05, 8'hff, 16, 32);
        wr(7'h00, 8'h7f, 16, 32);
        d0 = drops;
        wr(7'h01, ~mf, 10, 32);
        cmp(8'(drops), 8'(d0 + 1));
        wr(7'h01, 8'h61, 18, 32);
        wr(7'h01, 8'ha8, 16, 32);
        chk_out();
        wr(7'h00, 8'h80, 16, 32);
        cmp(slp, 1'b1);
        repeat (110) @(negedge clk);
        chk_out();
        wr(7'h01, 8'h49, 16, 32);
        strap = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            rnd = xs(rnd);
            par = (i < 4) ? {2'(i), rnd[1:0]} : rnd[3:0];
            repeat (8) @(negedge clk);
            cmp(pmode, 1'b1);
            if (par[3:2] != 2'h3)
                cmp(lane, par[3:2]);
            cmp(slp, par[1]);
            cmp(lvds, par[0]);
            cmp(dsd, 1'b0);
        end
        strap = 1'b0;
        repeat (8) @(negedge clk);
        cmp(pmode, 1'b0);
        chk_out();
        end_of_test();
    end
endmodule
`default_nettype wire
